//--- logic/gear_follower_setpoint.sv
/*
  Electronic-gear follower: decodes reference pulses, scales them by a
  signed ratio and builds the motor position setpoint.
  Assumes reference pins are asynchronous, error flags, drive state and
  motor position come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module gear_follower_setpoint
  import follow_pkg::*;
#(
  parameter int SP_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_a,
  input wire logic ref_b,
  input wire logic [1:0] ref_source_sel,
  input wire logic [3:0] drive_state,
  input wire logic motor_standstill,
  input wire logic signed [SP_W-1:0] motor_position,
  input wire drive_err_s drive_err,
  input wire par_req_s par_req,
  output logic [31:0] par_rdata,
  output logic par_rvalid,
  output logic signed [SP_W-1:0] setpoint,
  output logic follow_active
);

  // ***************************************************
  // reference pin synchronisers and decoding
  // ***************************************************
  logic [1:0] s1_reg, s2_reg, s3_reg, pin_reg, prev_reg;
  logic [1:0] s1_next, s2_next, s3_next, pin_next, prev_next;
  logic signed [1:0] step;

  // a bit is accepted once the second and third stages agree
  always_comb begin
    s1_next = {ref_a, ref_b};
    s2_next = s1_reg;
    s3_next = s2_reg;
    prev_next = pin_reg;
    for (int i = 0; i < 2; i++) begin
      pin_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : pin_reg[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      pin_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      pin_reg <= pin_next;
      prev_reg <= prev_next;
    end
  end

  // step is +1, -1 or 0 per cycle
  always_comb begin
    step = 2'sd0;
    case (ref_source_e'(ref_source_sel))
      SRC_QUAD: begin
        case ({prev_reg, pin_reg})
          4'b0001, 4'b0111, 4'b1110, 4'b1000: step = 2'sd1;
          4'b0010, 4'b1011, 4'b1101, 4'b0100: step = -2'sd1;
          default: step = 2'sd0;
        endcase
      end
      SRC_PULSE_DIR: begin
        if (pin_reg[1] && !prev_reg[1]) begin
          step = pin_reg[0] ? -2'sd1 : 2'sd1;
        end
      end
      SRC_FWD_BWD: begin
        // simultaneous edges cancel out
        if ((pin_reg[1] && !prev_reg[1]) && !(pin_reg[0] && !prev_reg[0])) begin
          step = 2'sd1;
        end else if ((pin_reg[0] && !prev_reg[0]) && !(pin_reg[1] && !prev_reg[1])) begin
          step = -2'sd1;
        end
      end
      default: step = 2'sd0;
    endcase
  end

  // ***************************************************
  // ratio scaling with carried remainder
  // ***************************************************
  logic signed [31:0] num_reg, den_reg, den_pend_reg, rem_reg;
  logic signed [31:0] num_next, den_next, den_pend_next, rem_next;
  logic signed [63:0] acc, quot, inc;
  logic wr_ok;

  assign wr_ok = par_req.wr && (par_req.idx == PAR_GROUP);

  // floor division keeps the remainder in 0..den-1 for both signs
  always_comb begin
    num_next = num_reg;
    den_next = den_reg;
    den_pend_next = den_pend_reg;
    acc = 64'(rem_reg) + 64'(step) * 64'(num_reg);
    quot = acc / 64'(den_reg);
    if ((acc % 64'(den_reg) != 0) && acc < 0) begin
      quot = quot - 64'sd1;
    end
    inc = quot;
    rem_next = 32'(acc - quot * 64'(den_reg));
    if (wr_ok && par_req.sub == SUB_DEN && $signed(par_req.wdata) > 0) begin
      den_pend_next = $signed(par_req.wdata);
    end
    if (wr_ok && par_req.sub == SUB_NUM) begin
      num_next = $signed(par_req.wdata);
      den_next = den_pend_reg;
      rem_next = 32'sd0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      num_reg <= NUM_RESET;
      den_reg <= DEN_RESET;
      den_pend_reg <= DEN_RESET;
      rem_reg <= 32'sd0;
    end else begin
      num_reg <= num_next;
      den_reg <= den_next;
      den_pend_reg <= den_pend_next;
      rem_reg <= rem_next;
    end
  end

  // ***************************************************
  // launch, state machine and setpoint
  // ***************************************************
  follow_state_e state_reg, state_next;
  logic [15:0] launch_reg, launch_next, dir_reg, dir_next;
  logic signed [SP_W-1:0] sp_reg, sp_next, missed_reg, missed_next;
  logic signed [SP_W-1:0] offs_reg, offs_next, delta;
  logic interrupted_reg, interrupted_next;
  logic op_en, launch_wr, start;

  assign op_en = (drive_state == DRIVE_OP_ENABLED);
  assign launch_wr = wr_ok && par_req.sub == SUB_LAUNCH;
  // a start code while already running is ignored, not a restart
  assign start = launch_wr && (par_req.wdata[15:0] == LAUNCH_IMMEDIATE
                               || par_req.wdata[15:0] == LAUNCH_COMPENSATE) && op_en
                 && state_reg != FOLLOW_RUN;

  // direction permit masks motion against the allowed sense
  function automatic logic signed [SP_W-1:0] gate(input logic signed [SP_W-1:0] d,
                                                   input logic [15:0] perm);
    if (perm == DIR_POS && d < 0) begin
      return '0;
    end else if (perm == DIR_NEG && d > 0) begin
      return '0;
    end
    return d;
  endfunction

  always_comb begin
    state_next = state_reg;
    launch_next = launch_reg;
    dir_next = dir_reg;
    sp_next = sp_reg;
    missed_next = missed_reg;
    offs_next = offs_reg;
    interrupted_next = interrupted_reg;
    delta = '0;
    if (wr_ok && par_req.sub == SUB_DIR && par_req.wdata[15:0] >= DIR_POS
        && par_req.wdata[15:0] <= DIR_RESET) begin
      dir_next = par_req.wdata[15:0];
    end
    case (state_reg)
      FOLLOW_IDLE, FOLLOW_STOP: begin
        // travel missed while off is kept for a compensating restart
        missed_next = missed_reg + SP_W'(inc);
        if (wr_ok && par_req.sub == SUB_OFFSET) begin
          offs_next = offs_reg + SP_W'($signed(par_req.wdata));
        end
        if (state_reg == FOLLOW_STOP && motor_standstill) begin
          state_next = FOLLOW_IDLE;
        end
        if (start) begin
          launch_next = par_req.wdata[15:0];
          interrupted_next = 1'b0;
          state_next = FOLLOW_RUN;
          missed_next = '0;
          offs_next = '0;
          if (par_req.wdata[15:0] == LAUNCH_COMPENSATE) begin
            delta = missed_reg + SP_W'(inc) + offs_reg;
          end
          // immediate start drops missed travel and offset, this cycle's step included
        end
      end
      FOLLOW_RUN: begin
        delta = SP_W'(inc);
        if (wr_ok && par_req.sub == SUB_OFFSET) begin
          delta = delta + SP_W'($signed(par_req.wdata));
        end
        if (!op_en) begin
          launch_next = LAUNCH_OFF;
          interrupted_next = 1'b1;
          state_next = FOLLOW_IDLE;
          delta = '0;
        end else if (launch_wr && par_req.wdata[15:0] == LAUNCH_OFF) begin
          launch_next = LAUNCH_OFF;
          state_next = FOLLOW_STOP;
        end
      end
      default: begin
        state_next = FOLLOW_IDLE;
        launch_next = LAUNCH_OFF;
      end
    endcase
    // no range clamp: following may run past the positioning limits
    sp_next = sp_reg + gate(delta, dir_reg);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FOLLOW_IDLE;
      launch_reg <= LAUNCH_RESET;
      dir_reg <= DIR_RESET;
      sp_reg <= '0;
      missed_reg <= '0;
      offs_reg <= '0;
      interrupted_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      launch_reg <= launch_next;
      dir_reg <= dir_next;
      sp_reg <= sp_next;
      missed_reg <= missed_next;
      offs_reg <= offs_next;
      interrupted_reg <= interrupted_next;
    end
  end

  assign setpoint = sp_reg;
  // run is the middle one-hot bit, so the output is a flop directly
  assign follow_active = state_reg[1];

  // ***************************************************
  // status word and parameter read back
  // ***************************************************
  logic [15:0] status;
  logic signed [SP_W-1:0] lag;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg;

  always_comb begin
    lag = sp_reg - motor_position;
    status = 16'h0000;
    status[ST_HW_POSITIVE_HW_LIMIT_ERROR] = drive_err.hw_positive_hw_limit_error;
    status[ST_HW_NEGATIVE_HW_LIMIT_ERROR] = drive_err.hw_negative_hw_limit_error;
    status[ST_HARDWARE_HALT_INPUT_ERROR] = drive_err.hardware_halt_input_error;
    status[ST_REF] = drive_err.ref_err;
    status[ST_POSITIVE_SOFT_LIMIT_ERROR] = drive_err.positive_soft_limit_error;
    status[ST_NEGATIVE_SOFT_LIMIT_ERROR] = drive_err.negative_soft_limit_error;
    status[ST_SOFTWARE_HALT_ERROR] = drive_err.software_halt_error;
    status[ST_SYNC] = follow_active && (lag <= $signed(SYNC_WINDOW_RESET))
                      && (lag >= -$signed(SYNC_WINDOW_RESET));
    status[ST_END] = (state_reg == FOLLOW_IDLE)
                     && (motor_standstill || interrupted_reg);
    status[ST_ERR] = |drive_err || interrupted_reg;
    rdata_next = rdata_reg;
    if (par_req.rd && par_req.idx == PAR_GROUP) begin
      case (par_req.sub)
        SUB_LAUNCH: rdata_next = {16'h0000, launch_reg};
        SUB_STATUS: rdata_next = {16'h0000, status};
        SUB_NUM: rdata_next = num_reg;
        SUB_DEN: rdata_next = den_pend_reg;
        SUB_DIR: rdata_next = {16'h0000, dir_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= par_req.rd;
    end
  end

  assign par_rdata = rdata_reg;
  assign par_rvalid = rvalid_reg;

  // ***************************************************
  // checks
  // ***************************************************
  chk_quad_up: assert property (@(posedge clk) disable iff (!rst_n)
    ref_source_sel == 2'b00 && prev_reg == 2'b00 && pin_reg == 2'b01 |-> step == 2'sd1)
    else $error("quadrature up edge not counted");
  chk_pulse_dir: assert property (@(posedge clk) disable iff (!rst_n)
    ref_source_sel == 2'b01 && pin_reg[1] && !prev_reg[1] |-> step != 2'sd0)
    else $error("pulse edge not counted");
  chk_same_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    follow_active && op_en && !par_req.wr && dir_reg == DIR_RESET
    |=> sp_reg == $past(sp_reg) + SP_W'($past(inc)))
    else $error("setpoint did not take the scaled step");
  chk_ratio_hold: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ok && par_req.sub == SUB_DEN |=> num_reg == $past(num_reg) && den_reg == $past(den_reg))
    else $error("denominator write changed active ratio");
  chk_den_pos: assert property (@(posedge clk) disable iff (!rst_n)
    den_reg > 0 && den_pend_reg > 0)
    else $error("denominator not positive");
  chk_state_leave: assert property (@(posedge clk) disable iff (!rst_n)
    follow_active && !op_en |=> !follow_active && launch_reg == LAUNCH_OFF)
    else $error("following kept running outside op enabled");
  chk_dir_permit: assert property (@(posedge clk) disable iff (!rst_n)
    dir_reg == DIR_POS |=> sp_reg >= $past(sp_reg))
    else $error("setpoint moved against permitted direction");
  chk_remainder: assert property (@(posedge clk) disable iff (!rst_n)
    rem_reg >= 0 && rem_reg < den_reg)
    else $error("remainder out of range");
  chk_end_flag: assert property (@(posedge clk) disable iff (!rst_n)
    follow_active |-> !status[ST_END])
    else $error("finished flagged while following");
  chk_imm_start: assert property (@(posedge clk) disable iff (!rst_n)
    start && par_req.wdata[15:0] == LAUNCH_IMMEDIATE |=> sp_reg == $past(sp_reg))
    else $error("immediate start moved the setpoint");

endmodule
`default_nettype wire

//--- common/follow_pkg.sv
/*
  Constants and types for the electronic-gear follower: parameter
  addresses, status word layout, launch codes and reset values.
  Assumes a single 10 MHz clock domain and the index:subindex
  parameter access used by the rest of the controller.
*/
package follow_pkg;
  // parameter addresses
  localparam logic [7:0] PAR_GROUP = 8'h26;
  localparam logic [7:0] SUB_LAUNCH = 8'h01;
  localparam logic [7:0] SUB_STATUS = 8'h02;
  localparam logic [7:0] SUB_NUM = 8'h07;
  localparam logic [7:0] SUB_DEN = 8'h08;
  localparam logic [7:0] SUB_OFFSET = 8'h0A;
  localparam logic [7:0] SUB_DIR = 8'h0D;
  // launch codes
  localparam logic [15:0] LAUNCH_OFF = 16'h0000;
  localparam logic [15:0] LAUNCH_IMMEDIATE = 16'h0001;
  localparam logic [15:0] LAUNCH_COMPENSATE = 16'h0002;
  localparam logic [15:0] LAUNCH_RESET = 16'h0000;
  // status word bit positions
  localparam int ST_HW_POSITIVE_HW_LIMIT_ERROR = 0;
  localparam int ST_HW_NEGATIVE_HW_LIMIT_ERROR = 1;
  localparam int ST_HARDWARE_HALT_INPUT_ERROR = 2;
  localparam int ST_REF = 3;
  localparam int ST_POSITIVE_SOFT_LIMIT_ERROR = 5;
  localparam int ST_NEGATIVE_SOFT_LIMIT_ERROR = 6;
  localparam int ST_SOFTWARE_HALT_ERROR = 7;
  localparam int ST_SYNC = 13;
  localparam int ST_END = 14;
  localparam int ST_ERR = 15;
  // reset values, direction permit codes and the operation enabled drive state
  localparam logic signed [31:0] NUM_RESET = 32'sh0000_0001;
  localparam logic signed [31:0] DEN_RESET = 32'sh0000_0001;
  localparam logic [15:0] DIR_RESET = 16'h0003;
  localparam logic [15:0] DIR_POS = 16'h0001;
  localparam logic [15:0] DIR_NEG = 16'h0002;
  localparam logic [3:0] DRIVE_OP_ENABLED = 4'h6;
  localparam logic [31:0] SYNC_WINDOW_RESET = 32'h0000_0004;

  // reference source selection
  typedef enum logic [1:0] {
    SRC_QUAD = 2'b00,
    SRC_PULSE_DIR = 2'b01,
    SRC_FWD_BWD = 2'b10
  } ref_source_e;

  // one-hot follower states
  typedef enum logic [2:0] {
    FOLLOW_IDLE = 3'b001,
    FOLLOW_RUN = 3'b010,
    FOLLOW_STOP = 3'b100
  } follow_state_e;

  // error flags reported by the rest of the drive
  typedef struct packed {
    logic hw_positive_hw_limit_error;
    logic hw_negative_hw_limit_error;
    logic hardware_halt_input_error;
    logic ref_err;
    logic positive_soft_limit_error;
    logic negative_soft_limit_error;
    logic software_halt_error;
  } drive_err_s;

  // parameter access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] sub;
    logic [31:0] wdata;
  } par_req_s;
endpackage

//--- verification/ref_pulse_source.sv
/*
  Reference pulse source standing in for the control unit or encoder.
  Assumes the bench calls step() just after a falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ref_pulse_source
  import follow_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] mode,
  output logic ref_a,
  output logic ref_b
);
  int ph = 0;
  initial {ref_a, ref_b} = 2'b00;
  // 6 cycles per level keeps edges well apart of the 4 cycle sync
  task automatic hold();
    repeat (6) @(negedge clk);
  endtask
  // one reference count; neg asks for the backward direction
  task automatic step(input bit neg);
    if (mode == SRC_QUAD) begin
      ph = (ph + (neg ? 3 : 1)) % 4;
      ref_b = (ph == 1 || ph == 2);
      ref_a = (ph >= 2);
      hold();
    end else begin
      if (mode == SRC_PULSE_DIR)
        ref_b = neg;
      hold();
      if (mode == SRC_PULSE_DIR || !neg)
        ref_a = 1'b1;
      else
        ref_b = 1'b1;
      hold();
      {ref_a, ref_b} = 2'b00;
      hold();
    end
  endtask
endmodule
`default_nettype wire

//--- verification/gear_follower_setpoint_tb_top.sv
/*
  Self-checking bench for the gear follower with an integer model.
  Assumes the follower's assertions live in the design files.
*/
`timescale 1ns/10ps
`default_nettype none
module gear_follower_setpoint_tb_top
  import follow_pkg::*;
;
  logic clk = 0;
  logic rst_n = 0;
  logic standstill = 1;
  logic [1:0] src = SRC_PULSE_DIR;
  logic [3:0] dstate = DRIVE_OP_ENABLED;
  logic signed [31:0] mpos = 0;
  drive_err_s derr = '0;
  par_req_s req = '0;
  logic [31:0] rdata;
  logic [31:0] rd_v;
  logic rvalid;
  logic act;
  logic ra;
  logic rb;
  logic signed [31:0] sp;
  int errors = 0;
  int tests_run = 0;
  int exp_sp = 0, num = 1, den = 1, pden = 1, rem = 0, perm = 3, miss = 0, offs = 0;
  bit run = 0;
  logic [7:0] rsub [5] = '{SUB_LAUNCH, SUB_NUM, SUB_DEN, SUB_DIR, 8'h30};
  logic [31:0] rexp [5] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001,
    32'h0000_0003, 32'h0000_0000};

  always #50 clk = ~clk;

  ref_pulse_source u_ref (.clk(clk), .mode(src), .ref_a(ra), .ref_b(rb));
  gear_follower_setpoint u_dut (.clk(clk), .rst_n(rst_n), .ref_a(ra), .ref_b(rb),
    .ref_source_sel(src), .drive_state(dstate), .motor_standstill(standstill),
    .motor_position(mpos), .drive_err(derr), .par_req(req), .par_rdata(rdata),
    .par_rvalid(rvalid), .setpoint(sp), .follow_active(act));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report();
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one-cycle request pulse; the extra edge lets the write land
  task automatic access(input bit w, input logic [7:0] sub, input logic [31:0] d);
    int n;
    @(negedge clk);
    req = '{wr: w, rd: !w, idx: PAR_GROUP, sub: sub, wdata: d};
    @(negedge clk);
    req = '0;
    n = 0;
    while (!w && rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (!w && rvalid !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t no read answer", $time);
      final_report();
    end else begin
      rd_v = rdata;
      @(negedge clk);
    end
  endtask
  // floor division, as the ratio scaling rounds down
  function automatic int fdiv(input int a, input int b);
    return (a < 0 && a % b != 0) ? a / b - 1 : a / b;
  endfunction
  // step the source, then advance the model; permit blocks a whole step
  task automatic step(input bit neg);
    int s;
    int inc;
    s = neg ? -1 : 1;
    u_ref.step(neg);
    if (!run)
      miss += s;
    else if (!((perm == 1 && neg) || (perm == 2 && !neg))) begin
      inc = fdiv(rem + s * num, den);
      rem = rem + s * num - inc * den;
      exp_sp += inc;
    end
    repeat (6) @(negedge clk);
    chk(sp, exp_sp, "setpoint after step");
  endtask
  function automatic logic [31:0] st(input bit win, input bit fin, input bit intr);
    logic [31:0] v;
    v = '0;
    v[3:0] = {derr.ref_err, derr.hardware_halt_input_error, derr.hw_negative_hw_limit_error, derr.hw_positive_hw_limit_error};
    v[7:5] = {derr.software_halt_error, derr.negative_soft_limit_error, derr.positive_soft_limit_error};
    v[15:13] = {(derr != '0) || intr, fin, win};
    return v;
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hc2a359ff));
    repeat (2) @(negedge clk);
    rst_n = 1;
    foreach (rsub[i]) begin
      access(0, rsub[i], 0);
      chk(rd_v, rexp[i], "reset value");
    end
    chk(sp, 0, "setpoint reset");
    repeat (3) step(0);
    access(1, SUB_OFFSET, 5);
    offs = 5;
    access(1, SUB_LAUNCH, LAUNCH_IMMEDIATE);
    run = 1;
    miss = 0;
    offs = 0;
    chk(sp, exp_sp, "immediate start");
    chk(act, 1, "following on");
    for (int m = 0; m < 3; m++) begin
      src = 2'((m + 1) % 3);
      repeat (3) @(negedge clk);
      repeat (6) step(1'($urandom));
    end
    access(1, SUB_DEN, 3);
    pden = 3;
    step(0);
    access(1, SUB_NUM, -2);
    num = -2;
    den = pden;
    rem = 0;
    repeat (6) step(1'($urandom));
    access(1, SUB_DEN, 0);
    access(1, SUB_NUM, 1);
    num = 1;
    rem = 0;
    repeat (4) step(0);
    access(1, SUB_DEN, 1);
    access(1, SUB_NUM, 1);
    den = 1;
    rem = 0;
    for (int p = 1; p < 3; p++) begin
      access(1, SUB_DIR, p);
      perm = p;
      repeat (4) step(1'($urandom));
    end
    access(1, SUB_DIR, 7);
    access(0, SUB_DIR, 0);
    chk(rd_v, 2, "permit out of range");
    access(1, SUB_DIR, 3);
    perm = 3;
    access(1, SUB_OFFSET, 32'h4000_0000);
    exp_sp += 32'h4000_0000;
    chk(sp, exp_sp, "offset in run");
    for (int i = 0; i < 4; i++) begin
      derr = (i == 3) ? '0 : drive_err_s'(7'($urandom));
      mpos = exp_sp + ((i % 2) ? -4 : 5);
      repeat (2) @(negedge clk);
      access(0, SUB_STATUS, 0);
      chk(rd_v, st(i % 2, 0, 0), "status in run");
    end
    standstill = 0;
    access(1, SUB_LAUNCH, LAUNCH_OFF);
    run = 0;
    chk(act, 0, "following off");
    access(0, SUB_STATUS, 0);
    chk(rd_v, st(0, 0, 0), "moving, not finished");
    standstill = 1;
    repeat (2) @(negedge clk);
    access(0, SUB_STATUS, 0);
    chk(rd_v, st(0, 1, 0), "finished");
    repeat (2) step(0);
    access(1, SUB_OFFSET, 7);
    offs = 7;
    access(1, SUB_LAUNCH, LAUNCH_COMPENSATE);
    run = 1;
    exp_sp += miss + offs;
    repeat (4) @(negedge clk);
    chk(sp, exp_sp, "compensating start");
    dstate = 4'h4;
    repeat (2) @(negedge clk);
    chk(act, 0, "left operation enabled");
    run = 0;
    access(1, SUB_LAUNCH, LAUNCH_IMMEDIATE);
    chk(act, 0, "start refused");
    access(0, SUB_STATUS, 0);
    chk(rd_v, st(0, 1, 1), "interrupted status");
    step(1);
    final_report();
  end

  // hang guard
  initial begin
    repeat (20000) @(negedge clk);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
